//--- hw/system_config_registers.sv
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/100ps
`include "sys_cfg_regs.svh"

module system_config_registers
	import sys_cfg_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire op_mode_t    op_mode,
	input  wire logic        rom_map_select,
	input  wire eeprom_req_t eeprom_req,
	input  wire logic        cfg_prog_req,
	input  wire logic        stop_exit_req,
	input  wire logic        clk_slow_detect,
	input  wire logic        instr_load_req,
	input  wire logic [7:0]  port_c_data,
	input  wire logic [7:0]  port_c_dir,
	input  wire logic        ext_access,
	input  wire logic [15:0] ext_addr,
	input  wire logic [3:0]  timer_flags,
	output logic             adc_power_up,
	output logic             pump_clock_select,
	output logic             irq_edge_select,
	output logic [1:0]       watchdog_rate_sel,
	output logic             clk_monitor_active,
	output logic             clk_fail_reset,
	output logic             stop_resume,
	output logic             instr_load_strobe_out,
	output logic             instr_load_strobe_oe,
	output logic [7:0]       port_c_out,
	output logic [7:0]       port_c_oe,
	output logic             ext_stretch,
	output logic             internal_read_visibility,
	output logic             bus_clock_out_en,
	output logic             serial_bit_order,
	output logic             serial_rate_extra_div,
	output logic             eeprom_window_hit,
	output logic             eeprom_prog_blocked,
	output logic             cfg_prog_blocked,
	output logic [3:0]       eeprom_page_select,
	output logic [1:0]       timer_prescale_sel,
	output logic             timer_tick,
	output logic             timer_irq
);

	////////////////////////////////////////////////////////////////////////

	function automatic logic [9:0] byte_addr(input logic [7:0] idx);
		byte_addr = {idx, 2'b00};
	endfunction

	function automatic logic [3:0] div_limit(input logic [1:0] sel);
		case (sel)
			2'b00:   div_limit = 4'd0;
			2'b01:   div_limit = 4'd3;
			2'b10:   div_limit = 4'd7;
			default: div_limit = 4'd15;
		endcase
	endfunction

	function automatic logic [4:0] region_of(input logic [11:0] off);
		logic [4:0] r;
		r = 5'b00000;
		if (off >= 12'hF80) begin
			r = 5'b10000;
		end else if (off >= 12'hE60) begin
			r = 5'b01000;
		end else if (off >= 12'hDE0) begin
			r = 5'b00100;
		end else if (off >= 12'hDA0) begin
			r = 5'b00010;
		end else if (off >= `EEPROM_WIN_BASE) begin
			r = 5'b00001;
		end
		region_of = r;
	endfunction

	////////////////////////////////////////////////////////////////////////

	logic [7:0]  opt1_q;
	logic [7:0]  opt1_d;
	logic [7:0]  system_options_2_q;
	logic [7:0]  system_options_2_d;
	logic [7:0]  eeprom_block_protect_q;
	logic [7:0]  eeprom_block_protect_d;
	logic [7:0]  tmask_q;
	logic [7:0]  tmask_d;
	logic [7:0]  emap_q;
	logic [7:0]  emap_d;
	logic        opt1_once_q;
	logic        eeprom_block_protect_once_q;
	logic        tmask_once_q;
	logic        emap_once_q;
	logic        vis_once_q;
	logic        vis_loaded_q;
	logic [6:0]  win_cnt_q;
	logic        dphase_q;
	logic        dwrite_q;
	logic [9:0]  daddr_q;
	logic [31:0] rdata_q;
	logic [3:0]  div_cnt_q;
	logic        tick_q;
	logic        irq_q;
	logic        fail_q;
	wake_state_t wake_q;
	wake_state_t wake_d;
	logic [11:0] wake_cnt_q;
	logic        load_out_q;
	logic        load_oe_q;

	wire [7:0] w = hwdata[7:0];
	wire special = op_mode.special;
	wire expanded = op_mode.expanded;
	wire test_mode = special & expanded;
	wire window_open = win_cnt_q < `PROTECT_WINDOW_CYC;
	wire addr_phase = hsel & htrans[1] & hready;
	wire wr = clk_en & dphase_q & dwrite_q;
	wire wr_opt1 = wr & (daddr_q == byte_addr(`REG_IDX_OPTIONS_1));
	wire wr_system_options_2 = wr & (daddr_q == byte_addr(`REG_IDX_OPTIONS_2));
	wire wr_eeprom_block_protect = wr & (daddr_q == byte_addr(`REG_IDX_BLOCK_PROTECT));
	wire wr_tmask = wr & (daddr_q == byte_addr(`REG_IDX_TIMER_MASK));
	wire wr_emap = wr & (daddr_q == byte_addr(`REG_IDX_EEPROM_MAP));

	// Normal modes get one write inside the window (map and visibility: one write any time); special modes any time, visibility only when also expanded.
	wire opt1_ok = special | (window_open & ~opt1_once_q);
	wire eeprom_block_protect_ok = special | (window_open & ~eeprom_block_protect_once_q);
	wire tmask_ok = special | (window_open & ~tmask_once_q);
	wire emap_ok = special | ~emap_once_q;
	wire vis_ok = test_mode | ~vis_once_q;

	////////////////////////////////////////////////////////////////////////

	assign opt1_d = {w[7:6],
		opt1_ok ? w[5:4] : opt1_q[5:4],
		w[3],
		opt1_q[2] | (opt1_ok & w[2]),
		opt1_ok ? w[1:0] : opt1_q[1:0]};
	assign system_options_2_d = {w[7:5],
		vis_ok ? w[4] : system_options_2_q[4],
		w[3:2], 2'b00};
	// Clearing is limited, setting never is.
	assign eeprom_block_protect_d = (eeprom_block_protect_ok ? w : (eeprom_block_protect_q | w))
		& `BLOCK_PROTECT_MASK;
	assign tmask_d = {w[7:4], 2'b00,
		tmask_ok ? w[1:0] : tmask_q[1:0]};
	assign emap_d = {emap_ok ? w[7:4] : emap_q[7:4], w[3:0]};

	wire [7:0] rd_mux =
		(haddr[9:0] == byte_addr(`REG_IDX_OPTIONS_1))     ? opt1_q  :
		(haddr[9:0] == byte_addr(`REG_IDX_OPTIONS_2))     ? system_options_2_q  :
		(haddr[9:0] == byte_addr(`REG_IDX_BLOCK_PROTECT)) ? eeprom_block_protect_q :
		(haddr[9:0] == byte_addr(`REG_IDX_TIMER_MASK))    ? tmask_q :
		(haddr[9:0] == byte_addr(`REG_IDX_EEPROM_MAP))    ? emap_q  :
		8'h00;

	// Zero wait states; unmapped words read zero and ignore writes.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			dphase_q <= 1'b0;
			dwrite_q <= 1'b0;
			daddr_q <= 10'h000;
			rdata_q <= 32'h0000_0000;
		end else if (clk_en) begin
			dphase_q <= addr_phase;
			dwrite_q <= hwrite;
			daddr_q <= haddr[9:0];
			if (addr_phase && !hwrite) begin
				rdata_q <= {24'h00_0000, rd_mux};
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			win_cnt_q <= 7'd0;
		end else if (clk_en && window_open) begin
			win_cnt_q <= win_cnt_q + 7'd1;
		end
	end

	////////////////////////////////////////////////////////////////////////

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			opt1_q <= `RST_OPTIONS_1;
			system_options_2_q <= `RST_OPTIONS_2;
			eeprom_block_protect_q <= `RST_BLOCK_PROTECT;
			tmask_q <= `RST_TIMER_MASK;
			emap_q <= `RST_EEPROM_MAP;
			opt1_once_q <= 1'b0;
			eeprom_block_protect_once_q <= 1'b0;
			tmask_once_q <= 1'b0;
			emap_once_q <= 1'b0;
			vis_once_q <= 1'b0;
			vis_loaded_q <= 1'b0;
		end else if (clk_en) begin
			// The mode strap is caught on the first enabled edge.
			if (!vis_loaded_q) begin
				vis_loaded_q <= 1'b1;
				system_options_2_q[`SYSTEM_OPTIONS_2_VISIBILITY] <= test_mode;
			end else if (wr_system_options_2) begin
				system_options_2_q <= system_options_2_d;
				vis_once_q <= 1'b1;
			end
			if (wr_opt1) begin
				opt1_q <= opt1_d;
				opt1_once_q <= 1'b1;
			end
			if (wr_eeprom_block_protect) begin
				eeprom_block_protect_q <= eeprom_block_protect_d;
				eeprom_block_protect_once_q <= 1'b1;
			end
			if (wr_tmask) begin
				tmask_q <= tmask_d;
				tmask_once_q <= 1'b1;
			end
			if (wr_emap) begin
				emap_q <= emap_d;
				emap_once_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////

	assign adc_power_up = opt1_q[`OPT1_ADC_POWER];
	assign pump_clock_select = opt1_q[`OPT1_PUMP_CLK];
	assign irq_edge_select = opt1_q[`OPT1_IRQ_EDGE];
	assign watchdog_rate_sel = opt1_q[1:0];
	assign clk_monitor_active = opt1_q[`OPT1_MON_EN]
		| opt1_q[`OPT1_MON_FORCE];
	assign serial_bit_order = system_options_2_q[`SYSTEM_OPTIONS_2_BIT_ORDER];
	assign serial_rate_extra_div = system_options_2_q[`SYSTEM_OPTIONS_2_EXTRA_DIV];
	assign internal_read_visibility = expanded
		& system_options_2_q[`SYSTEM_OPTIONS_2_VISIBILITY];
	assign bus_clock_out_en = expanded
		| ~system_options_2_q[`SYSTEM_OPTIONS_2_VISIBILITY];
	assign port_c_out = port_c_data;
	// Open-drain only ever pulls low, so a driven one floats.
	assign port_c_oe = port_c_dir & ~(port_c_data
		& {8{system_options_2_q[`SYSTEM_OPTIONS_2_PORTC_OD]}});
	assign ext_stretch = ext_access & expanded
		& system_options_2_q[`SYSTEM_OPTIONS_2_STRETCH]
		& (ext_addr[15] == ~rom_map_select);
	assign eeprom_page_select = emap_q[7:4];
	assign timer_prescale_sel = tmask_q[1:0];
	assign timer_tick = tick_q;
	assign timer_irq = irq_q;
	assign clk_fail_reset = fail_q;
	assign stop_resume = wake_q == WAKE_DONE;
	assign instr_load_strobe_out = load_out_q;
	assign instr_load_strobe_oe = load_oe_q;
	assign cfg_prog_blocked = cfg_prog_req & ~special
		& eeprom_block_protect_q[`BPR_CFG];

	wire [4:0] region_prot = {eeprom_block_protect_q[`BPR_REGION4], eeprom_block_protect_q[3:0]};
	assign eeprom_window_hit = (eeprom_req.addr[15:12] == emap_q[7:4])
		& (eeprom_req.addr[11:0] >= `EEPROM_WIN_BASE);
	wire whole_erase = eeprom_req.erase & eeprom_req.whole;
	assign eeprom_prog_blocked = eeprom_req.prog & eeprom_window_hit
		& ((|(region_of(eeprom_req.addr[11:0]) & region_prot))
		| (whole_erase & eeprom_block_protect_q[`BPR_BULK]));

	////////////////////////////////////////////////////////////////////////

	wire tick_now = div_cnt_q >= div_limit(tmask_q[1:0]);

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			div_cnt_q <= 4'd0;
			tick_q <= 1'b0;
			irq_q <= 1'b0;
			fail_q <= 1'b0;
		end else if (clk_en) begin
			div_cnt_q <= tick_now ? 4'd0 : div_cnt_q + 4'd1;
			tick_q <= tick_now;
			irq_q <= |(timer_flags & tmask_q[7:4]);
			fail_q <= clk_monitor_active & clk_slow_detect;
		end
	end

	// Stop exit delay is taken from the bit at the moment of the request.
	always_comb begin
		wake_d = wake_q;
		case (wake_q)
			WAKE_IDLE: begin
				if (stop_exit_req) begin
					wake_d = WAKE_WAIT;
				end
			end
			WAKE_WAIT: begin
				if (wake_cnt_q == 12'd1) begin
					wake_d = WAKE_DONE;
				end
			end
			WAKE_DONE: wake_d = WAKE_IDLE;
			default:   wake_d = WAKE_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wake_q <= WAKE_IDLE;
			wake_cnt_q <= 12'd0;
		end else if (clk_en) begin
			wake_q <= wake_d;
			if (wake_q == WAKE_IDLE) begin
				wake_cnt_q <= opt1_q[`OPT1_STOP_DELAY]
					? `STOP_DELAY_LONG_CYC
					: `STOP_DELAY_SHORT_CYC;
			end else if (wake_q == WAKE_WAIT) begin
				wake_cnt_q <= wake_cnt_q - 12'd1;
			end
		end
	end

	// The pin pulls low for the strobe; the high kick is one core cycle,
	// the nearest this clock gets to a quarter bus cycle.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			load_out_q <= 1'b0;
			load_oe_q <= 1'b0;
		end else if (clk_en) begin
			if (instr_load_req) begin
				load_out_q <= 1'b0;
				load_oe_q <= 1'b1;
			end else begin
				load_out_q <= load_oe_q & ~load_out_q;
				load_oe_q <= load_oe_q & ~load_out_q & expanded
					& system_options_2_q[`SYSTEM_OPTIONS_2_LOAD_DRIVE];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence s_late_opt1_wr;
		wr_opt1 && !special && !window_open;
	endsequence

	sequence s_short_wake;
		stop_exit_req && wake_q == WAKE_IDLE && clk_en
			&& !opt1_q[`OPT1_STOP_DELAY] ##1 clk_en[*4];
	endsequence

	sequence s_div4_tick;
		(timer_tick && clk_en && tmask_q[1:0] == 2'b01)
			##1 (clk_en && !wr_tmask && tmask_q[1:0] == 2'b01)[*4];
	endsequence

	a_late_option_lock: assert property (s_late_opt1_wr |=>
		$stable(opt1_q[5:4]) && $stable(opt1_q[1:0]))
		else $error("protected option bits changed after the window");

	a_protect_set_only: assert property (wr_eeprom_block_protect && !special
		&& eeprom_block_protect_once_q |=> (eeprom_block_protect_q & $past(eeprom_block_protect_q)) == $past(eeprom_block_protect_q))
		else $error("block protect bit cleared outside its chance");

	a_force_mon_sticky: assert property (opt1_q[`OPT1_MON_FORCE]
		|=> opt1_q[`OPT1_MON_FORCE] && clk_monitor_active)
		else $error("forced clock monitor dropped before reset");

	a_wake_short_delay: assert property (s_short_wake |=>
		stop_resume)
		else $error("short stop exit did not resume on time");

	a_prescale_div4: assert property (s_div4_tick |-> timer_tick
		&& !$past(timer_tick, 1) && !$past(timer_tick, 3))
		else $error("divide by four tick spacing wrong");

	a_timer_irq_pair: assert property (clk_en
		&& (|(timer_flags & tmask_q[7:4])) |=> timer_irq)
		else $error("masked timer flag raised no interrupt");

	a_stretch_expanded: assert property (ext_stretch |-> expanded
		&& (ext_addr[15] != rom_map_select))
		else $error("stretch outside expanded mapped half");

	a_vis_write_once: assert property (wr_system_options_2 && !test_mode
		&& vis_once_q |=> $stable(system_options_2_q[`SYSTEM_OPTIONS_2_VISIBILITY]))
		else $error("visibility bit written twice in user mode");

	a_tmask_lock: assert property (wr_tmask && !special
		&& !window_open |=> $stable(timer_prescale_sel))
		else $error("prescale select changed after the window");

endmodule

//--- shared/sys_cfg_regs.svh
`ifndef SYS_CFG_REGS_SVH
`define SYS_CFG_REGS_SVH

`define REG_IDX_TIMER_MASK    8'h24
`define REG_IDX_BLOCK_PROTECT 8'h35
`define REG_IDX_EEPROM_MAP    8'h37
`define REG_IDX_OPTIONS_2     8'h38
`define REG_IDX_OPTIONS_1     8'h39

`define RST_TIMER_MASK        8'h00
`define RST_BLOCK_PROTECT     8'hBF
`define RST_EEPROM_MAP        8'h00
`define RST_OPTIONS_2         8'h00
`define RST_OPTIONS_1         8'h10
`define BLOCK_PROTECT_MASK    8'hBF
`define OPTIONS_2_MASK        8'hFC
`define TIMER_MASK_MASK       8'hF3

`define OPT1_ADC_POWER        7
`define OPT1_PUMP_CLK         6
`define OPT1_IRQ_EDGE         5
`define OPT1_STOP_DELAY       4
`define OPT1_MON_EN           3
`define OPT1_MON_FORCE        2
`define SYSTEM_OPTIONS_2_LOAD_DRIVE       7
`define SYSTEM_OPTIONS_2_PORTC_OD         6
`define SYSTEM_OPTIONS_2_STRETCH          5
`define SYSTEM_OPTIONS_2_VISIBILITY       4
`define SYSTEM_OPTIONS_2_BIT_ORDER        3
`define SYSTEM_OPTIONS_2_EXTRA_DIV        2
`define BPR_BULK              7
`define BPR_CFG               4
`define BPR_REGION4           5

`define PROTECT_WINDOW_CYC    7'd64
`define STOP_DELAY_LONG_CYC   12'd4064
`define STOP_DELAY_SHORT_CYC  12'd4
`define EEPROM_WIN_BASE       12'hD80

`endif

//--- shared/sys_cfg_pkg.sv
package sys_cfg_pkg;

	typedef enum logic [2:0] {
		WAKE_IDLE = 3'b001,
		WAKE_WAIT = 3'b010,
		WAKE_DONE = 3'b100
	} wake_state_t;

	typedef struct packed {
		logic special;
		logic expanded;
	} op_mode_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        prog;
		logic        erase;
		logic        whole;
	} eeprom_req_t;

endpackage

//--- sim/system_config_registers_tb.sv
`timescale 1ns/100ps
`include "sys_cfg_regs.svh"

module system_config_registers_tb
	import sys_cfg_pkg::*;
();

////////////////////////////////////////////////////////////////////////////////
localparam logic [31:0] A_TMR = {22'h0, `REG_IDX_TIMER_MASK, 2'b00};
localparam logic [31:0] A_BPR = {22'h0, `REG_IDX_BLOCK_PROTECT, 2'b00};
localparam logic [31:0] A_MAP = {22'h0, `REG_IDX_EEPROM_MAP, 2'b00};
localparam logic [31:0] A_OP2 = {22'h0, `REG_IDX_OPTIONS_2, 2'b00};
localparam logic [31:0] A_OP1 = {22'h0, `REG_IDX_OPTIONS_1, 2'b00};

logic              core_clk, resetn, clk_en, hsel, hwrite, hreadyout, hresp;
logic       [31:0] haddr, hwdata, hrdata;
logic       [1:0]  htrans, watchdog_rate_sel, timer_prescale_sel;
logic       [2:0]  hsize;
op_mode_t          op_mode;
eeprom_req_t       eeprom_req;
logic              rom_map_select, cfg_prog_req, stop_exit_req;
logic              clk_slow_detect, instr_load_req, ext_access;
logic       [7:0]  port_c_data, port_c_dir, port_c_out, port_c_oe;
logic       [15:0] ext_addr;
logic       [3:0]  timer_flags, eeprom_page_select;
logic              adc_power_up, pump_clock_select, irq_edge_select;
logic              clk_monitor_active, clk_fail_reset, stop_resume;
logic              instr_load_strobe_out, instr_load_strobe_oe, ext_stretch;
logic              internal_read_visibility, bus_clock_out_en;
logic              serial_bit_order, serial_rate_extra_div;
logic              eeprom_window_hit, eeprom_prog_blocked, cfg_prog_blocked;
logic              timer_tick, timer_irq;
int                n_fail, tests_run;

system_config_registers system_config_registers_i (
	.core_clk, .resetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize,
	.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .op_mode,
	.rom_map_select, .eeprom_req, .cfg_prog_req, .stop_exit_req,
	.clk_slow_detect, .instr_load_req, .port_c_data, .port_c_dir,
	.ext_access, .ext_addr, .timer_flags, .adc_power_up, .pump_clock_select,
	.irq_edge_select, .watchdog_rate_sel, .clk_monitor_active,
	.clk_fail_reset, .stop_resume, .instr_load_strobe_out,
	.instr_load_strobe_oe, .port_c_out, .port_c_oe, .ext_stretch,
	.internal_read_visibility, .bus_clock_out_en, .serial_bit_order,
	.serial_rate_extra_div, .eeprom_window_hit, .eeprom_prog_blocked,
	.cfg_prog_blocked, .eeprom_page_select, .timer_prescale_sel,
	.timer_tick, .timer_irq
);

always #5 core_clk = ~core_clk;

////////////////////////////////////////////////////////////////////////////////
task automatic print_verdict();
	if (n_fail == 0 && tests_run > 0)
		$display("*** PASS ***");
	else
		$display("*** FAIL ***");
	$finish;
endtask

task automatic check(input logic [31:0] seen, input logic [31:0] exp);
	tests_run++;
	if (seen !== exp) begin
		n_fail++;
		$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
	end
endtask

// The slave inserts no waits, but the master still polls and never assumes a latency.
task automatic wait_ready();
	int k;
	k = 0;
	do begin
		@(posedge core_clk);
		k++;
	end while (hreadyout !== 1'b1 && k < 100);
	if (k >= 100) begin
		n_fail++;
		print_verdict();
	end
endtask

task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] d,
		output logic [31:0] r);
	@(posedge core_clk);
	hsel <= 1'b1;
	haddr <= a;
	hwrite <= w;
	htrans <= 2'b10;
	wait_ready();
	hsel <= 1'b0;
	htrans <= 2'b00;
	hwdata <= {24'h0, d};
	wait_ready();
	r = hrdata;
endtask

// Outputs move on the edge that lands the write, so look just after it.
task automatic wr(input logic [31:0] a, input logic [7:0] d);
	logic [31:0] r;
	bus(a, 1'b1, d, r);
	#1;
endtask

task automatic rd(input logic [31:0] a, input logic [7:0] exp);
	logic [31:0] r;
	bus(a, 1'b0, 8'h00, r);
	check(r, {24'h0, exp});
endtask

task automatic rst(input logic sp, input logic ex);
	@(posedge core_clk);
	resetn <= 1'b0;
	op_mode <= '{special: sp, expanded: ex};
	repeat (8) @(posedge core_clk);
	resetn <= 1'b1;
endtask

task automatic step();
	@(posedge core_clk);
	#1;
endtask

task automatic ee(input logic [15:0] a, input logic p, input logic e,
		input logic w, input logic [2:0] exp);
	@(posedge core_clk);
	eeprom_req <= '{addr: a, prog: p, erase: e, whole: w};
	step();
	check({eeprom_window_hit, eeprom_prog_blocked, cfg_prog_blocked}, exp);
endtask

task automatic ticks(input logic [31:0] exp);
	logic [31:0] c;
	c = 0;
	repeat (32) begin
		step();
		if (timer_tick === 1'b1)
			c++;
	end
	check(c, exp);
endtask

// Counts enabled edges from the edge that takes the request to the pulse.
task automatic wake(input logic [31:0] exp);
	int n;
	@(posedge core_clk);
	stop_exit_req <= 1'b1;
	@(posedge core_clk);
	stop_exit_req <= 1'b0;
	for (n = 1; n < 5000; n++) begin
		step();
		if (stop_resume === 1'b1)
			break;
	end
	check(n, exp);
endtask

////////////////////////////////////////////////////////////////////////////////
initial begin
	#200000;
	n_fail++;
	print_verdict();
end

initial begin
	core_clk = 1'b0;
	n_fail = 0;
	tests_run = 0;
	resetn <= 1'b0;
	clk_en <= 1'b1;
	hsel <= 1'b0;
	haddr <= 32'h0;
	htrans <= 2'b00;
	hwrite <= 1'b0;
	hsize <= 3'h2;
	hwdata <= 32'h0;
	op_mode <= '{special: 1'b0, expanded: 1'b1};
	rom_map_select <= 1'b1;
	eeprom_req <= '{addr: 16'h0D80, prog: 1'b1, erase: 1'b0, whole: 1'b0};
	cfg_prog_req <= 1'b1;
	stop_exit_req <= 1'b0;
	clk_slow_detect <= 1'b0;
	instr_load_req <= 1'b0;
	port_c_data <= 8'h0F;
	port_c_dir <= 8'hFF;
	ext_access <= 1'b1;
	ext_addr <= 16'h1000;
	timer_flags <= 4'h0;
	// Normal expanded mode: protected bits open only briefly after reset.
	rst(1'b0, 1'b1);
	ee(16'h0D80, 1'b1, 1'b0, 1'b0, 3'b111);
	rd(A_TMR, 8'h00);
	rd(A_BPR, 8'hBF);
	rd(A_OP2, 8'h00);
	rd(A_OP1, 8'h10);
	rd(32'h3FC, 8'h00);
	check({hreadyout, hresp}, 2'b10);
	wr(A_OP1, 8'h25);
	wr(A_OP1, 8'h10);
	wr(A_TMR, 8'h01);
	wr(A_BPR, 8'h00);
	wr(A_MAP, 8'h30);
	wr(A_OP2, 8'hF8);
	check(serial_bit_order, 1'b1);
	wr(A_OP2, 8'hE4);
	rd(A_OP1, 8'h25);
	check({irq_edge_select, watchdog_rate_sel, clk_monitor_active}, 4'hB);
	rd(A_MAP, 8'h30);
	check(eeprom_page_select, 4'h3);
	rd(A_OP2, 8'hF4);
	check({serial_bit_order, serial_rate_extra_div}, 2'b01);
	check({internal_read_visibility, bus_clock_out_en}, 2'b11);
	check({port_c_out, port_c_oe}, 16'h0FF0);
	check(ext_stretch, 1'b1);
	ext_addr <= 16'h9000;
	step();
	check(ext_stretch, 1'b0);
	rom_map_select <= 1'b0;
	step();
	check(ext_stretch, 1'b1);
	repeat (64) @(posedge core_clk);
	wr(A_TMR, 8'hF2);
	rd(A_TMR, 8'hF1);
	wr(A_BPR, 8'h01);
	wr(A_BPR, 8'h00);
	rd(A_BPR, 8'h01);
	ee(16'h3D80, 1'b1, 1'b0, 1'b0, 3'b110);
	ee(16'h3DA0, 1'b1, 1'b0, 1'b0, 3'b100);
	ee(16'h0DA0, 1'b0, 1'b1, 1'b1, 3'b000);
	wr(A_BPR, 8'h80);
	ee(16'h3DA0, 1'b1, 1'b1, 1'b1, 3'b110);
	wr(A_OP1, 8'hC8);
	rd(A_OP1, 8'hED);
	check({adc_power_up, pump_clock_select}, 2'b11);
	ticks(32'd8);
	wr(A_TMR, 8'h11);
	timer_flags <= 4'b1110;
	step();
	step();
	check(timer_irq, 1'b0);
	timer_flags <= 4'b0001;
	step();
	step();
	check(timer_irq, 1'b1);
	@(posedge core_clk);
	instr_load_req <= 1'b1;
	@(posedge core_clk);
	instr_load_req <= 1'b0;
	#1;
	check({instr_load_strobe_oe, instr_load_strobe_out}, 2'b10);
	step();
	check({instr_load_strobe_oe, instr_load_strobe_out}, 2'b11);
	step();
	check(instr_load_strobe_oe, 1'b0);
	@(posedge core_clk);
	clk_slow_detect <= 1'b1;
	step();
	step();
	check(clk_fail_reset, 1'b1);
	clk_slow_detect <= 1'b0;
	wake(32'd4);
	// Special test mode lifts the once-only and time limits.
	rst(1'b1, 1'b1);
	rd(A_OP2, 8'h10);
	check(internal_read_visibility, 1'b1);
	ee(16'h0D80, 1'b1, 1'b0, 1'b0, 3'b110);
	repeat (70) @(posedge core_clk);
	wr(A_OP1, 8'h34);
	rd(A_OP1, 8'h34);
	wake(32'd4064);
	wr(A_TMR, 8'h03);
	check(timer_prescale_sel, 2'b11);
	ticks(32'd2);
	wr(A_OP2, 8'h00);
	wr(A_OP2, 8'h10);
	rd(A_OP2, 8'h10);
	// Normal single chip mode, first writes arrive after the window.
	rst(1'b0, 1'b0);
	repeat (70) @(posedge core_clk);
	wr(A_OP1, 8'h3F);
	rd(A_OP1, 8'h18);
	check(clk_monitor_active, 1'b1);
	wr(A_BPR, 8'h00);
	rd(A_BPR, 8'hBF);
	check(bus_clock_out_en, 1'b1);
	wr(A_OP2, 8'h10);
	step();
	check(bus_clock_out_en, 1'b0);
	print_verdict();
end

endmodule
